// file: design/smta_pkg.sv
package smta_pkg;
  // Command byte layout
  localparam int CMD_RW_BIT = 7;
  localparam int OPC_HI = 6;
  localparam int OPC_LO = 3;
  localparam int CODE_HI = 3;
  localparam int CODE_LO = 0;
  localparam int UD_BIT = 7;
  // Operation codes
  localparam logic [3:0] OPC_DM_ALL = 4'h1;
  localparam logic [3:0] OPC_DM_HI4 = 4'h3;
  localparam logic [3:0] OPC_DM_LO4 = 4'h2;
  localparam logic [3:0] OPC_DM_P3 = 4'h7;
  localparam logic [3:0] OPC_DM_P2 = 4'h6;
  localparam logic [3:0] OPC_DM_P1 = 4'h5;
  localparam logic [3:0] OPC_DM_P0 = 4'h4;
  localparam logic [3:0] OPC_TS_ONE = 4'hC;
  localparam logic [3:0] OPC_TS_ALL = 4'hD;
  localparam logic [3:0] OPC_CM_DATA = 4'h9;
  localparam logic [2:0] OPC_CM_BOTH = 3'h7;
  // Sizes and timing
  localparam int ADDR_W = 8;
  localparam int DEPTH = 256;
  localparam int TS_DEPTH = 128;
  localparam logic [3:0] SINGLE_CYCLES = 4'h9;
  localparam int TS_ALL_CYCLES = 1035;
  localparam logic [10:0] TS_ALL_CNT = 11'(TS_ALL_CYCLES - 1);
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] TS_RST = 4'h0;
  typedef enum logic [1:0] {SMTA_IDLE, SMTA_SINGLE, SMTA_SWEEP} smta_state_t;
endpackage

// file: design/smta_subslot_drive.sv
`timescale 1ns/1ps
// Per-bit PCM transmit drive from data and tristate nibble
module smta_subslot_drive (
  input wire logic [7:0] slot_data_i,
  input wire logic [3:0] subslot_enable_bits_i,
  input wire logic [2:0] bit_pos_i,
  output logic tx_data_o,
  output logic tx_oe_o,
  output logic output_enable_line_n_o
);
  logic en;
  always_comb begin
    en = subslot_enable_bits_i[bit_pos_i[2:1]]; // RQ4
    tx_data_o = slot_data_i[bit_pos_i]; // RQ10
    tx_oe_o = en; // RQ2
    output_enable_line_n_o = ~en; // RQ3
  end
endmodule // smta_subslot_drive

// file: design/smta_mask.sv
`timescale 1ns/1ps
// Merge of new data into a timeslot under an operation-code mask
module smta_mask (
  input wire logic [3:0] opcode_i,
  input wire logic [7:0] old_i,
  input wire logic [7:0] new_i,
  output logic [7:0] merged_o
);
  import smta_pkg::*;
  logic [7:0] m;
  always_comb begin
    unique case (opcode_i) // RQ20
      OPC_DM_ALL: m = 8'hFF; // RQ11
      OPC_DM_HI4: m = 8'hF0;
      OPC_DM_LO4: m = 8'h0F; // RQ12
      OPC_DM_P3: m = 8'hC0;
      OPC_DM_P2: m = 8'h30;
      OPC_DM_P1: m = 8'h0C;
      OPC_DM_P0: m = 8'h03;
      default: m = 8'h00;
    endcase
    merged_o = (new_i & m) | (old_i & ~m);
  end
endmodule // smta_mask

// file: design/smta_core.sv
`timescale 1ns/1ps
// Functional notes
// RQ1: Tristate field only for upstream buffer
// RQ2: Low impedance drives data, control line low
// RQ3: High impedance floats line, control high
// RQ4: Four enable bits, one per subslot
// RQ5: Tristate uses low data nibble only
// RQ6: Code 1100 exchanges nibble with field
// RQ7: Code 1101 fills all fields, 1035 cycles
// RQ8: Host commands 60h, E0h, 68h
// RQ9: Tristate access forces upstream select
// RQ10: Idle code sent only when enabled
// RQ11: Code 0001 writes all eight bits
// RQ12: Code 0010 writes bits 3..0 only
// RQ13: Four-bit function code per timeslot
// RQ14: Code 111X writes data and code
// RQ15: Code 1001 touches only data field
// RQ16: Host reads data with C8h
// RQ17: Host writes data only with 48h
// RQ18: Host polls busy before reading
// RQ19: Busy set from command until done
// RQ20: Data-write codes select subslot bits
// RQ21: Busy covers broadcast tristate pass
module smta_core (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic data_wr_i,
  input wire logic addr_wr_i,
  input wire logic cmd_wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [smta_pkg::ADDR_W-1:0] tx_slot_i,
  input wire logic [2:0] tx_bit_i,
  input wire logic [smta_pkg::ADDR_W-1:0] rx_slot_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_wr_i,
  output logic [7:0] access_data_reg_o,
  output logic [7:0] access_address_reg_o,
  output logic [7:0] access_command_reg_o,
  output logic access_busy_flag_o,
  output logic [3:0] line_function_code_o,
  output logic [7:0] line_data_o,
  output logic tx_data_o,
  output logic tx_oe_o,
  output logic output_enable_line_n_o
);
  import smta_pkg::*;
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0] up_mem [0:TS_DEPTH-1];
  logic [7:0] dn_mem [0:TS_DEPTH-1];
  logic [3:0] ts_mem [0:TS_DEPTH-1]; // RQ1
  logic [7:0] cm_data [0:DEPTH-1];
  logic [3:0] cm_code [0:DEPTH-1]; // RQ13
  logic [7:0] data_reg, data_next;
  logic [7:0] addr_reg, addr_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [10:0] sweep_reg, sweep_next;
  smta_state_t state_reg, state_next;
  logic [3:0] opc;
  logic [6:0] slot;
  logic is_read, is_ts, ts_we, dm_we, cm_dwe, cm_cwe, done;
  logic [7:0] merged;
  function automatic logic is_dm_write(input logic [3:0] o);
    return (o[3:2] == 2'b00 && o != 4'h0) || o[3:2] == 2'b01;
  endfunction
  // Tristate commands and data-memory writes always land in the upstream block
  function automatic logic forces_upstream(input logic [7:0] c);
    logic [3:0] o;
    o = c[OPC_HI:OPC_LO];
    return (o[3:1] == 3'h6) || (!c[CMD_RW_BIT] && is_dm_write(o));
  endfunction

  assign opc = cmd_reg[OPC_HI:OPC_LO];
  assign is_read = cmd_reg[CMD_RW_BIT];
  assign slot = addr_reg[6:0];
  assign is_ts = (opc == OPC_TS_ONE) || (opc == OPC_TS_ALL);
  smta_mask u_mask (
    .opcode_i(opc),
    .old_i(up_mem[slot]),
    .new_i(data_reg),
    .merged_o(merged)
  );

  // ---------------------------------------------------------------
  // Command sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    sweep_next = sweep_reg;
    data_next = data_reg;
    addr_next = addr_reg;
    cmd_next = cmd_reg;
    ts_we = 1'b0;
    dm_we = 1'b0;
    cm_dwe = 1'b0;
    cm_cwe = 1'b0;
    done = 1'b0;
    unique case (state_reg)
      SMTA_IDLE: begin
        if (data_wr_i) begin
          data_next = wdata_i;
        end
        if (addr_wr_i) begin
          addr_next = wdata_i;
        end
        if (cmd_wr_i) begin
          cmd_next = wdata_i;
          if (wdata_i[OPC_HI:OPC_LO] == OPC_TS_ALL && !wdata_i[CMD_RW_BIT]) begin
            state_next = SMTA_SWEEP; // RQ21
            sweep_next = 11'h000;
          end else begin
            state_next = SMTA_SINGLE; // RQ19
            cnt_next = 4'h0;
          end
          if (forces_upstream(wdata_i)) begin
            addr_next[UD_BIT] = 1'b1; // RQ9
          end
        end
      end
      SMTA_SINGLE: begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == SINGLE_CYCLES - 4'h1) begin
          done = 1'b1;
          state_next = SMTA_IDLE;
          if (is_read) begin
            if (is_ts) begin
              data_next = {4'h0, ts_mem[slot]}; // RQ6
            end else if (opc[3:1] == OPC_CM_BOTH) begin
              data_next = {4'h0, cm_code[addr_reg]};
            end else if (opc == OPC_CM_DATA) begin
              data_next = cm_data[addr_reg]; // RQ15
            end else begin
              data_next = addr_reg[UD_BIT] ? up_mem[slot] : dn_mem[slot];
            end
          end else begin
            ts_we = (opc == OPC_TS_ONE); // RQ6
            dm_we = is_dm_write(opc); // RQ20
            cm_dwe = (opc == OPC_CM_DATA) || (opc[3:1] == OPC_CM_BOTH); // RQ14
            cm_cwe = (opc[3:1] == OPC_CM_BOTH); // RQ14
          end
        end
      end
      SMTA_SWEEP: begin
        ts_we = 1'b1; // RQ7
        sweep_next = sweep_reg + 11'h001;
        if (sweep_reg == TS_ALL_CNT) begin
          done = 1'b1;
          state_next = SMTA_IDLE;
        end
      end
      default: state_next = SMTA_IDLE;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= SMTA_IDLE;
      cnt_reg <= 4'h0;
      sweep_reg <= 11'h000;
      data_reg <= DATA_RST;
      addr_reg <= DATA_RST;
      cmd_reg <= DATA_RST;
    end else if (ce_i) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sweep_reg <= sweep_next;
      data_reg <= data_next;
      addr_reg <= addr_next;
      cmd_reg <= cmd_next;
    end
  end

  // ---------------------------------------------------------------
  // Memory writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (ts_we) begin
        if (state_reg == SMTA_SWEEP) begin
          ts_mem[sweep_reg[6:0]] <= data_reg[3:0]; // RQ5
        end else begin
          ts_mem[slot] <= data_reg[3:0]; // RQ5
        end
      end
      if (dm_we) begin
        up_mem[slot] <= merged; // RQ11
      end
      if (rx_wr_i) begin
        dn_mem[rx_slot_i[6:0]] <= rx_data_i;
      end
      if (cm_dwe) begin
        cm_data[addr_reg] <= data_reg;
      end
      if (cm_cwe) begin
        cm_code[addr_reg] <= cmd_reg[CODE_HI:CODE_LO];
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Enables read as zero in reset so the transmit line floats
  logic [3:0] tx_en;
  assign tx_en = reset_i ? TS_RST : ts_mem[tx_slot_i[6:0]];
  smta_subslot_drive u_drive (
    .slot_data_i(up_mem[tx_slot_i[6:0]]),
    .subslot_enable_bits_i(tx_en),
    .bit_pos_i(tx_bit_i),
    .tx_data_o(tx_data_o),
    .tx_oe_o(tx_oe_o),
    .output_enable_line_n_o(output_enable_line_n_o)
  );
  assign access_data_reg_o = data_reg;
  assign access_address_reg_o = addr_reg;
  assign access_command_reg_o = cmd_reg;
  assign access_busy_flag_o = (state_reg != SMTA_IDLE); // RQ19
  assign line_function_code_o = cm_code[tx_slot_i];
  assign line_data_o = cm_data[tx_slot_i];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Length of the current busy period
  int unsigned busy_len;
  always_ff @(posedge clk_i) begin
    if (reset_i || !access_busy_flag_o) begin
      busy_len <= 0;
    end else if (ce_i) begin
      busy_len <= busy_len + 1;
    end
  end
  busy_start_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && cmd_wr_i && state_reg == SMTA_IDLE) |=> access_busy_flag_o) // RQ19
    else $error("busy not raised by command");
  sweep_len_a: assert property (@(posedge clk_i) disable iff (reset_i)
    busy_len <= 1035) // RQ7
    else $error("broadcast pass too long");
  ts_drive_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ2
    tx_en[tx_bit_i[2:1]] |-> tx_oe_o && !output_enable_line_n_o)
    else $error("control line disagrees with drive");
  ts_float_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !tx_en[tx_bit_i[2:1]] |-> !tx_oe_o && output_enable_line_n_o) // RQ3
    else $error("disabled subslot driven");
  ud_force_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_reg == SMTA_SINGLE && is_ts) |-> addr_reg[UD_BIT]) // RQ9
    else $error("upstream select not forced");
  ts_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && ts_we && state_reg == SMTA_SINGLE) |=> ts_mem[$past(slot)] == $past(data_reg[3:0])) // RQ6
    else $error("tristate field not written");
  lo_keep_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (dm_we && opc == OPC_DM_LO4) |-> merged[7:4] == up_mem[slot][7:4]) // RQ12
    else $error("upper bits disturbed");
  code_keep_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (cm_dwe && opc == OPC_CM_DATA) |-> !cm_cwe) // RQ15
    else $error("code field touched");
  sweep_done_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_reg == SMTA_SWEEP && sweep_reg == TS_ALL_CNT && ce_i) |=> !access_busy_flag_o) // RQ21
    else $error("busy held after pass");
  busy_hold_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ19
    (ce_i && state_reg != SMTA_IDLE && !done) |=> $stable(data_reg) && $stable(addr_reg) && $stable(cmd_reg))
    else $error("register changed while busy");
  single_len_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ19
    (state_reg == SMTA_SINGLE) |-> cnt_reg < SINGLE_CYCLES)
    else $error("single access too long");
  sweep_busy_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ21
    (state_reg == SMTA_SWEEP) |-> sweep_reg < 11'(TS_ALL_CYCLES))
    else $error("broadcast counter overran");
  ce_freeze_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !ce_i |=> $stable(state_reg) && $stable(cnt_reg) && $stable(sweep_reg) && $stable(data_reg))
    else $error("state moved while enable low");
  ts_read_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ5
    (ce_i && done && is_read && (is_ts || opc[3:1] == OPC_CM_BOTH)) |=> access_data_reg_o[7:4] == 4'h0)
    else $error("upper read bits not clear");
  sweep_write_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ7
    (ce_i && state_reg == SMTA_SWEEP) |=> ts_mem[$past(sweep_reg[6:0])] == $past(data_reg[3:0]))
    else $error("broadcast location not written");
  dm_all_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ11
    (dm_we && opc == OPC_DM_ALL) |-> merged == data_reg)
    else $error("full idle code not taken");
  cm_both_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ14
    (ce_i && cm_cwe) |=> cm_code[$past(addr_reg)] == $past(cmd_reg[CODE_HI:CODE_LO]))
    else $error("function code not stored");
  cm_data_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ15
    (ce_i && cm_dwe) |=> cm_data[$past(addr_reg)] == $past(data_reg))
    else $error("line data not stored");
  ud_keep_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ9
    (ce_i && cmd_wr_i && !addr_wr_i && state_reg == SMTA_IDLE && wdata_i[CMD_RW_BIT] && !wdata_i[OPC_HI])
    |=> $stable(addr_reg))
    else $error("select bit forced on plain read");
  idle_quiet_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ19
    (state_reg == SMTA_IDLE) |-> !ts_we && !dm_we && !cm_dwe && !cm_cwe)
    else $error("memory written while idle");
  dn_store_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && rx_wr_i) |=> dn_mem[$past(rx_slot_i[6:0])] == $past(rx_data_i))
    else $error("received byte not stored");

  // ---------------------------------------------------------------
  // Coverage
  // ---------------------------------------------------------------
  single_c: cover property (@(posedge clk_i) state_reg == SMTA_SINGLE && done && ts_we);
  sweep_c: cover property (@(posedge clk_i) state_reg == SMTA_SWEEP && done);
  cm_c: cover property (@(posedge clk_i) cm_cwe);
  ignored_c: cover property (@(posedge clk_i) access_busy_flag_o && data_wr_i);
  down_c: cover property (@(posedge clk_i) done && is_read && !addr_reg[UD_BIT]);
endmodule // smta_core

// file: verif/smta_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Processor side of the indirect access port
// ----------------------------------------
module smta_host (
  input wire logic clk_i,
  input wire logic busy_i,
  output logic data_wr_o,
  output logic addr_wr_o,
  output logic cmd_wr_o,
  output logic [7:0] wdata_o
);
  logic [2:0] stb = 3'h0;
  assign {cmd_wr_o, addr_wr_o, data_wr_o} = stb;
  initial wdata_o = 8'h00;
  // One-cycle strobe; bus shows inverse value once released
  task automatic pulse(input int which, input logic [7:0] v);
    @(negedge clk_i);
    wdata_o = v;
    stb = 3'b001 << which;
    @(negedge clk_i);
    stb = 3'h0;
    wdata_o = ~v;
  endtask
  // Full access; n counts busy cycles, poke writes data while busy
  task automatic access(input logic [7:0] d, input logic [7:0] a, input logic [7:0] c,
                        input bit poke, output int n);
    pulse(0, d);
    pulse(1, a);
    pulse(2, c);
    n = 0;
    while (busy_i === 1'b1 && n < 2000) begin
      n++;
      stb = (poke && n == 2) ? 3'b001 : 3'b000;
      @(negedge clk_i);
    end
    stb = 3'h0;
  endtask
endmodule // smta_host

// file: verif/switch_memory_tristate_access_tb.sv
`timescale 1ns/1ps
module switch_memory_tristate_access_tb;
  import smta_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic data_wr, addr_wr, cmd_wr, busy, txd, txoe, tsc_n, rx_wr = 1'b0;
  logic [7:0] wdata, dreg, areg, creg, ldata, tx_slot = 8'h00, rx_slot = 8'h00, rx_data = 8'h00;
  logic [7:0] d, d0, a;
  logic [3:0] fcode, ts;
  logic [2:0] tx_bit = 3'h0;
  logic ce = 1'b1;
  logic [31:0] seed = 32'h1CAD30AC;
  logic [3:0] opcs [7] = '{OPC_DM_ALL, OPC_DM_HI4, OPC_DM_LO4, OPC_DM_P3, OPC_DM_P2, OPC_DM_P1, OPC_DM_P0};
  int n, miscompares = 0, checks_done = 0, cycles = 0;
  always #2 clk = ~clk;
  smta_core smta_core_i (.clk_i(clk), .reset_i(reset), .ce_i(ce), .data_wr_i(data_wr), .addr_wr_i(addr_wr),
    .cmd_wr_i(cmd_wr), .wdata_i(wdata), .tx_slot_i(tx_slot), .tx_bit_i(tx_bit), .rx_slot_i(rx_slot),
    .rx_data_i(rx_data), .rx_wr_i(rx_wr), .access_data_reg_o(dreg), .access_address_reg_o(areg),
    .access_command_reg_o(creg), .access_busy_flag_o(busy), .line_function_code_o(fcode),
    .line_data_o(ldata), .tx_data_o(txd), .tx_oe_o(txoe), .output_enable_line_n_o(tsc_n));
  smta_host smta_host_i (.clk_i(clk), .busy_i(busy), .data_wr_o(data_wr), .addr_wr_o(addr_wr),
    .cmd_wr_o(cmd_wr), .wdata_o(wdata));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  function automatic logic [7:0] merge(input logic [3:0] opc, input logic [7:0] o, input logic [7:0] v);
    logic [7:0] m;
    case (opc)
      OPC_DM_ALL: m = 8'hFF;
      OPC_DM_HI4: m = 8'hF0;
      OPC_DM_LO4: m = 8'h0F;
      OPC_DM_P3: m = 8'hC0;
      OPC_DM_P2: m = 8'h30;
      OPC_DM_P1: m = 8'h0C;
      default: m = 8'h03;
    endcase
    return (o & ~m) | (v & m);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      miscompares++;
      summarize();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (10) @(negedge clk);
    reset = 1'b0;
    foreach (opcs[k]) begin
      a = {1'b1, 7'(rnd())};
      d0 = rnd();
      d = rnd();
      smta_host_i.access(d0, a, 8'h08, k == 0, n);
      chk(dreg, d0);
      chk(16'(n), 16'(SINGLE_CYCLES));
      smta_host_i.access(d, a, {1'b0, opcs[k], 3'h0}, 0, n);
      smta_host_i.access(8'h00, a, 8'h88, 0, n);
      chk(dreg, merge(opcs[k], d0, d));
    end
    $display("test data_field done");
    for (int k = 0; k < 4; k++) begin
      a = {1'b0, 7'(rnd())};
      d = rnd();
      ts = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : 4'(rnd());
      smta_host_i.access(d, a | 8'h80, 8'h08, 0, n);
      smta_host_i.access({4'(rnd()), ts}, a, 8'h60, 0, n);
      chk(areg, a | 8'h80);
      smta_host_i.access(8'h00, a | 8'h80, 8'hE0, 0, n);
      chk(dreg, {4'h0, ts});
      chk(creg, 8'hE0);
      tx_slot = a;
      for (int b = 0; b < 8; b++) begin
        @(negedge clk);
        tx_bit = 3'(b);
        #1;
        chk_bit(txoe, ts[b / 2]);
        chk_bit(tsc_n, ~ts[b / 2]);
        if (ts[b / 2]) chk_bit(txd, d[b]);
      end
    end
    $display("test tristate done");
    ts = 4'(rnd());
    smta_host_i.access({4'hA, ts}, rnd(), 8'h68, 0, n);
    chk(16'(n), 16'(TS_ALL_CYCLES));
    for (int k = 0; k < 3; k++) begin
      smta_host_i.access(8'h00, {1'b1, (k == 0) ? 7'h00 : (k == 1) ? 7'h7F : 7'(rnd())}, 8'hE0, 0, n);
      chk(dreg, {4'h0, ts});
    end
    $display("test broadcast done");
    for (int k = 0; k < 3; k++) begin
      a = rnd();
      ts = 4'(rnd());
      d = rnd();
      d0 = rnd();
      smta_host_i.access(d, a, {4'h7, ts}, 0, n);
      @(negedge clk);
      tx_slot = a;
      #1;
      chk(ldata, d);
      chk(fcode, ts);
      smta_host_i.access(d0, a, 8'h48, 0, n);
      chk(ldata, d0);
      chk(fcode, ts);
      smta_host_i.access(8'h00, a, 8'hC8, 0, n);
      chk(dreg, d0);
      smta_host_i.access(8'h00, a, 8'hF0, 0, n);
      chk(dreg[3:0], ts);
    end
    $display("test line_memory done");
    rx_slot = {1'b0, 7'(rnd())};
    rx_data = rnd();
    rx_wr = 1'b1;
    @(negedge clk);
    rx_wr = 1'b0;
    fork
      smta_host_i.access(8'h00, rx_slot, 8'h88, 0, n);
      begin
        repeat (8) @(negedge clk);
        ce = 1'b0;
        repeat (3) @(negedge clk);
        ce = 1'b1;
      end
    join
    chk(dreg, rx_data);
    chk(areg, rx_slot);
    chk(16'(n), 16'(SINGLE_CYCLES) + 16'h0003);
    $display("test downstream done");
    summarize();
  end
endmodule // switch_memory_tristate_access_tb
